// ### include/lrol_pkg.sv
`default_nettype none
package lrol_pkg;
  // -------------------------------------------------------------------------
  // Sizes and timing
  // -------------------------------------------------------------------------
  localparam int TRIG_N        = 7;
  localparam int MAX_CH        = 16;
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_TICK_MS     = 1;
  localparam int TICK_CYCLES   = T_TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_TICKS   = BLINK_HALF_MS / T_TICK_MS;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int TIM_W         = 16;
  // -------------------------------------------------------------------------
  // Register offsets and fields
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CH_CFG     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL     = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_TIMING     = 8'h48;
  localparam int                CFG_ASG_LSB    = 0;
  localparam int                CFG_INV_LSB    = 8;
  localparam int                CFG_CHINV_BIT  = 16;
  localparam int                CFG_OPMODE_BIT = 17;
  localparam int                CFG_LATCH_BIT  = 18;
  localparam int                CFG_ACKEN_BIT  = 19;
  localparam int                STAT_LATCH_LSB = 16;
  localparam int                GLB_REMOTE_BIT = 0;
  localparam int                TIM_HOLD_LSB   = 0;
  localparam int                TIM_OFF_LSB    = 16;
  localparam logic [TIM_W-1:0]  THOLD_RST      = 16'h0000;
  localparam logic [TIM_W-1:0]  TOFF_RST       = 16'h0000;
  localparam logic              REMOTE_RST     = 1'b0;
  // -------------------------------------------------------------------------
  // Sequencer states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESTORE_RD = 2'b00,
    ST_RESTORE_LD = 2'b01,
    ST_RUN        = 2'b11
  } lrol_fsm_t;
endpackage
`default_nettype wire

// ### include/lrol_store_if.sv
`default_nettype none
interface lrol_store_if #(parameter int W = 4);
  logic         wr_en;
  logic [W-1:0] wr_data;
  logic         rd_en;
  logic [W-1:0] rd_data;
  modport host (output wr_en, output wr_data, output rd_en, input rd_data);
  modport mem  (input wr_en, input wr_data, input rd_en, output rd_data);
endinterface
`default_nettype wire

// ### verilog/lrol_store.sv
`default_nettype none
module lrol_store
  import lrol_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic    ref_clk_i,
  input  wire logic    ce_i,
  lrol_store_if.mem    st_if
);
  // -------------------------------------------------------------------------
  // Retained word
  // -------------------------------------------------------------------------
  // The word has no reset on purpose: it models storage that survives a
  // restart, so the latched contacts can be rebuilt after srst_i.
  // Fresh storage reads back as all contacts released.
  typedef struct packed {
    logic [W-1:0] word;
    logic [W-1:0] rd;
  } lrol_store_t;

  lrol_store_t r = '0;
  lrol_store_t n;

  always_comb begin
    n = r;
    if (st_if.wr_en) begin
      n.word = st_if.wr_data;
    end
    if (st_if.rd_en) begin
      n.rd = r.word;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      r <= n;
    end
  end

  assign st_if.rd_data = r.rd;
endmodule // lrol_store
`default_nettype wire

// ### verilog/lrol_top.sv
// What this block does
// [RULE_01] A channel's collective state is the OR of its seven trigger inputs.
// [RULE_02] Each of the seven triggers has its own inversion before the OR.
// [RULE_03] An unassigned trigger always adds zero, inverted or not.
// [RULE_04] A channel inversion flips the collective state driving the relay.
// [RULE_05] With no trigger assigned the channel inversion is void, state is zero.
// [RULE_06] A per-channel mode picks working current or closed-circuit drive.
// [RULE_07] Without latching the output simply follows the collective state.
// [RULE_08] With latching the output state is stored until validly acknowledged.
// [RULE_09] The per-channel acknowledge input works only when latching, triggers inactive.
// [RULE_10] Acknowledge is taken only after triggers drop and off-delay has run.
// [RULE_11] Every output change is held at least the configured hold time.
// [RULE_12] Latch also clears when latching is disabled or nothing is assigned.
// [RULE_13] Latched states survive restarts and are restored afterwards.
// [RULE_14] The panel clear key acknowledges latched outputs locally.
// [RULE_15] The group acknowledge signal acknowledges all outputs together.
// [RULE_16] A SCADA acknowledge from the master releases all outputs at once.
// [RULE_17] Group and SCADA acknowledge count only while remote reset is enabled.
// [RULE_18] System-OK contact stays off during boot, picks up when healthy.
// [RULE_19] System-OK lamp flashes while booting, then stays steady green.
// [RULE_20] When latching, an active collective state sets and holds the latch.
`default_nettype none
module lrol_top
  import lrol_pkg::*;
#(
  parameter int NUM_CH   = 4,
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     ce_i,
  input  wire logic [ADDR_W-1:0]        addr_i,
  input  wire logic [DATA_W-1:0]        wr_data_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  input  wire logic [NUM_CH*TRIG_N-1:0] trig_i,
  input  wire logic [NUM_CH-1:0]        ack_sig_i,
  input  wire logic                     clear_key_i,
  input  wire logic                     group_output_ack_signal_i,
  input  wire logic                     scada_ack_i,
  input  wire logic                     boot_done_i,
  input  wire logic                     fault_i,
  output logic      [DATA_W-1:0]        rd_data_o,
  output logic      [NUM_CH-1:0]        relay_o,
  output logic                          system_ok_contact_o,
  output logic                          system_ok_led_o
);
  // -------------------------------------------------------------------------
  // Elaboration checks and derived sizes
  // -------------------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 16");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  localparam int               PW     = $clog2(TICK_CYC);
  localparam int               BW     = $clog2(BLINK_TICKS + 1);
  localparam logic [PW-1:0]    PRE_TOP = PW'(TICK_CYC - 1);
  localparam logic [BW-1:0]    BL_TOP  = BW'(BLINK_TICKS - 1);
  localparam logic [4:0]       CH_LIM  = 5'(NUM_CH);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    lrol_fsm_t                              fsm;
    logic [PW-1:0]                          pre;
    logic                                   tick;
    logic [NUM_CH-1:0][TRIG_N-1:0]          asg;
    logic [NUM_CH-1:0][TRIG_N-1:0]          inv;
    logic [NUM_CH-1:0]                      chinv;
    logic [NUM_CH-1:0]                      opmode;
    logic [NUM_CH-1:0]                      latch_en;
    logic [NUM_CH-1:0]                      ack_en;
    logic [NUM_CH-1:0]                      armed;
    logic [NUM_CH-1:0]                      latch;
    logic [NUM_CH-1:0]                      st;
    logic [NUM_CH-1:0]                      relay;
    logic                                   remote_en;
    logic [TIM_W-1:0]                       thold;
    logic [TIM_W-1:0]                       toff;
    logic [NUM_CH-1:0][TIM_W-1:0]           hold_cnt;
    logic [NUM_CH-1:0][TIM_W-1:0]           off_cnt;
    logic [BW-1:0]                          blink_cnt;
    logic                                   blink;
    logic                                   sok;
    logic                                   led;
    logic [DATA_W-1:0]                      rdata;
  } lrol_state_t;

  lrol_state_t          r;
  lrol_state_t          n;
  logic [NUM_CH-1:0]    coll_v;
  lrol_store_if #(.W(NUM_CH)) st_if ();

  lrol_store #(.W(NUM_CH)) u_store (
    .ref_clk_i (ref_clk_i),
    .ce_i      (ce_i),
    .st_if     (st_if.mem)
  );

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    logic [TRIG_N-1:0] terms;
    logic              coll;
    logic              quiet;
    logic              ack;
    logic              remote_ack;
    logic              target;
    logic              cfg_hit;
    terms      = '0;
    coll       = 1'b0;
    quiet      = 1'b0;
    ack        = 1'b0;
    target     = 1'b0;
    coll_v     = '0;
    n          = r;
    n.rdata    = '0;
    n.tick     = 1'b0;
    remote_ack = r.remote_en & (group_output_ack_signal_i | scada_ack_i); // see [RULE_17]
    cfg_hit    = (addr_i[7:6] == OFS_CH_CFG[7:6]) && (addr_i[1:0] == 2'b00)
                 && ({1'b0, addr_i[5:2]} < CH_LIM);

    if (r.pre == PRE_TOP) begin
      n.pre  = '0;
      n.tick = 1'b1;
    end else begin
      n.pre = r.pre + 1'b1;
    end

    // Register writes; channel writes also arm the channel after a restart.
    if (wr_i) begin
      if (addr_i == OFS_GLOBAL) begin
        n.remote_en = wr_data_i[GLB_REMOTE_BIT];
      end
      if (addr_i == OFS_TIMING) begin
        n.thold = wr_data_i[TIM_HOLD_LSB +: TIM_W];
        n.toff  = wr_data_i[TIM_OFF_LSB +: TIM_W];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (cfg_hit && addr_i[5:2] == 4'(c)) begin
          n.asg[c]      = wr_data_i[CFG_ASG_LSB +: TRIG_N];
          n.inv[c]      = wr_data_i[CFG_INV_LSB +: TRIG_N];
          n.chinv[c]    = wr_data_i[CFG_CHINV_BIT];
          n.opmode[c]   = wr_data_i[CFG_OPMODE_BIT];
          n.latch_en[c] = wr_data_i[CFG_LATCH_BIT];
          n.ack_en[c]   = wr_data_i[CFG_ACKEN_BIT];
          n.armed[c]    = 1'b1;
        end
      end
    end

    // Register reads; data stand for exactly one cycle.
    if (rd_i) begin
      if (addr_i == OFS_GLOBAL) begin
        n.rdata[GLB_REMOTE_BIT] = r.remote_en;
      end
      if (addr_i == OFS_TIMING) begin
        n.rdata = {r.toff, r.thold};
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (addr_i == OFS_STATUS) begin
          n.rdata[c]                  = r.st[c];
          n.rdata[STAT_LATCH_LSB + c] = r.latch[c];
        end
        if (cfg_hit && addr_i[5:2] == 4'(c)) begin
          n.rdata[CFG_ASG_LSB +: TRIG_N] = r.asg[c];
          n.rdata[CFG_INV_LSB +: TRIG_N] = r.inv[c];
          n.rdata[CFG_CHINV_BIT]         = r.chinv[c];
          n.rdata[CFG_OPMODE_BIT]        = r.opmode[c];
          n.rdata[CFG_LATCH_BIT]         = r.latch_en[c];
          n.rdata[CFG_ACKEN_BIT]         = r.ack_en[c];
        end
      end
    end

    case (r.fsm)
      ST_RESTORE_RD: begin
        n.fsm = ST_RESTORE_LD;
      end
      ST_RESTORE_LD: begin
        // The store answers one cycle after the read, hence this extra state.
        n.latch = st_if.rd_data; // see [RULE_13]
        n.st    = st_if.rd_data;
        n.fsm   = ST_RUN;
      end
      ST_RUN: begin
        for (int c = 0; c < NUM_CH; c++) begin
          terms     = (trig_i[c*TRIG_N +: TRIG_N] ^ r.inv[c]) & r.asg[c]; // see [RULE_02] [RULE_03]
          coll      = (|r.asg[c]) & ((|terms) ^ r.chinv[c]); // see [RULE_01] [RULE_04] [RULE_05]
          coll_v[c] = coll;
          if (coll) begin
            n.off_cnt[c] = r.toff;
          end else if (r.tick && r.off_cnt[c] != '0) begin
            n.off_cnt[c] = r.off_cnt[c] - 1'b1;
          end
          quiet = !coll && (r.off_cnt[c] == '0); // see [RULE_10]
          ack   = clear_key_i | remote_ack // see [RULE_14] [RULE_15] [RULE_16]
                  | (r.ack_en[c] & r.latch_en[c] & ack_sig_i[c]); // see [RULE_09]
          // A restored channel keeps its latch until a valid acknowledge or until software
          // configures it, otherwise the reset defaults would wipe the retained state.
          if (!r.armed[c]) begin
            if (quiet && ack) begin
              n.latch[c] = 1'b0;
            end
            target = r.latch[c] | coll;
          end else if (r.latch_en[c]) begin
            if (coll) begin
              n.latch[c] = 1'b1; // see [RULE_08] [RULE_20]
            end else if (quiet && (ack || r.asg[c] == '0)) begin
              n.latch[c] = 1'b0; // see [RULE_12]
            end
            target = r.latch[c] | coll;
          end else begin
            if (quiet) begin
              n.latch[c] = 1'b0; // see [RULE_12]
            end
            target = coll; // see [RULE_07]
          end
          if (r.hold_cnt[c] != '0) begin
            if (r.tick) begin
              n.hold_cnt[c] = r.hold_cnt[c] - 1'b1;
            end
          end else if (target != r.st[c]) begin
            n.st[c]       = target; // see [RULE_11]
            n.hold_cnt[c] = r.thold;
          end
        end
      end
      default: begin
        n.fsm = ST_RESTORE_RD;
      end
    endcase

    // Closed-circuit mode energises the coil while the state is inactive.
    n.relay = r.st ^ r.opmode; // see [RULE_06]

    // -----------------------------------------------------------------------
    // System-OK contact and lamp
    // -----------------------------------------------------------------------
    if (r.tick) begin
      if (r.blink_cnt == BL_TOP) begin
        n.blink_cnt = '0;
        n.blink     = !r.blink;
      end else begin
        n.blink_cnt = r.blink_cnt + 1'b1;
      end
    end
    // The lamp stays steady through a fault; only the contact reports it.
    n.sok = boot_done_i & !fault_i; // see [RULE_18]
    n.led = boot_done_i ? 1'b1 : r.blink; // see [RULE_19]
  end

  // Writes only on change so the retained word is touched as little as possible.
  assign st_if.wr_en   = (r.fsm == ST_RUN) && (n.latch != r.latch); // see [RULE_13]
  assign st_if.wr_data = n.latch;
  assign st_if.rd_en   = (r.fsm == ST_RESTORE_RD);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r           <= '0;
      r.remote_en <= REMOTE_RST;
      r.thold     <= THOLD_RST;
      r.toff      <= TOFF_RST;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign rd_data_o           = r.rdata;
  assign relay_o             = r.relay;
  assign system_ok_contact_o = r.sok;
  assign system_ok_led_o     = r.led;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Per-channel checks look at registered state, so a bus write in the
  // same cycle cannot make them fire early.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    latch_set_a: assert property ( // see [RULE_20]
      ce_i && r.fsm == ST_RUN && r.armed[c] && r.latch_en[c] && coll_v[c]
      |=> r.latch[c])
      else $error("latch not set by active state");
    follow_state_a: assert property ( // see [RULE_07]
      ce_i && r.fsm == ST_RUN && r.armed[c] && !r.latch_en[c] && r.hold_cnt[c] == '0
      |=> r.st[c] == $past(coll_v[c]))
      else $error("unlatched output does not follow");
    hold_time_a: assert property ( // see [RULE_11]
      ce_i && r.fsm == ST_RUN && r.hold_cnt[c] != '0 |=> $stable(r.st[c]))
      else $error("output changed during hold");
    off_delay_a: assert property ( // see [RULE_10]
      $past(ce_i) && $past(r.fsm) == ST_RUN && $fell(r.latch[c])
      |-> $past(!coll_v[c] && r.off_cnt[c] == '0))
      else $error("latch cleared before off-delay");
    remote_gate_a: assert property ( // see [RULE_17]
      ce_i && r.fsm == ST_RUN && r.armed[c] && r.latch_en[c] && r.asg[c] != '0
      && r.latch[c] && !r.remote_en && !clear_key_i && !(r.ack_en[c] && ack_sig_i[c])
      |=> r.latch[c])
      else $error("latch released without enabled acknowledge");
    relay_mode_a: assert property ( // see [RULE_06]
      ce_i ##1 1'b1 |-> relay_o[c] == $past(r.st[c] ^ r.opmode[c]))
      else $error("relay drive does not match mode");
    unassigned_zero_a: assert property ( // see [RULE_05]
      ce_i && r.fsm == ST_RUN && r.asg[c] == '0 |-> !coll_v[c])
      else $error("unassigned channel shows active state");
    unlatch_clear_a: assert property ( // see [RULE_12]
      ce_i && r.fsm == ST_RUN && r.armed[c] && !r.latch_en[c] && !coll_v[c]
      && r.off_cnt[c] == '0 |=> !r.latch[c])
      else $error("latch kept after latching was disabled");
    off_reload_a: assert property ( // see [RULE_10]
      ce_i && r.fsm == ST_RUN && coll_v[c] |=> r.off_cnt[c] == $past(r.toff))
      else $error("off-delay not reloaded while active");
  end

  restore_load_a: assert property ( // see [RULE_13]
    ce_i && r.fsm == ST_RESTORE_LD |=> r.latch == $past(st_if.rd_data))
    else $error("retained latch not restored");
  sok_boot_a: assert property ( // see [RULE_18]
    ce_i && (!boot_done_i || fault_i) |=> !system_ok_contact_o)
    else $error("system contact picked up while unhealthy");
  sok_pickup_a: assert property ( // see [RULE_18]
    ce_i && boot_done_i && !fault_i |=> system_ok_contact_o)
    else $error("system contact not picked up while healthy");
  led_steady_a: assert property ( // see [RULE_19]
    ce_i && boot_done_i ##1 ce_i && boot_done_i |=> system_ok_led_o [*1])
    else $error("system lamp not steady after boot");

  latch_ack_c: cover property (r.fsm == ST_RUN ##1 $fell(r.latch[0]));
  remote_ack_c: cover property (r.remote_en && scada_ack_i && r.latch != '0);
  boot_flash_c: cover property (!boot_done_i && $rose(system_ok_led_o));
  hold_block_c: cover property (r.hold_cnt[0] != '0 && coll_v[0] != r.st[0]);
  ce_freeze_c: cover property (!ce_i && coll_v[0] != r.st[0]);
endmodule // lrol_top
`default_nettype wire

// ### test/lrol_load_model.sv
`default_nettype none
module lrol_load_model #(
  parameter int N = 2
) (
  input  wire logic [N-1:0] coil_i,
  output logic      [N-1:0] closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // An energised coil closes its normally open contact. Bounce is left out
  // so that the bench can compare the contact to the exact cycle.
  assign closed_o = coil_i;
endmodule // lrol_load_model
`default_nettype wire

// ### test/tb_lrol_top.sv
`default_nettype none
module tb_lrol_top
  import lrol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 2;
  typedef struct packed {
    logic [6:0] asg;
    logic [6:0] inv;
    logic [3:0] f;
    logic [6:0] t;
    logic       e;
  } lrol_row_t;
  // Flags are {ack enable, latching, closed-circuit, channel invert}.
  localparam lrol_row_t ROWS [11] = '{
    '{7'h01, 7'h00, 4'h0, 7'h01, 1'b1},
    '{7'h01, 7'h00, 4'h0, 7'h00, 1'b0},
    '{7'h60, 7'h00, 4'h0, 7'h40, 1'b1},
    '{7'h03, 7'h02, 4'h0, 7'h02, 1'b0},
    '{7'h03, 7'h02, 4'h0, 7'h00, 1'b1},
    '{7'h02, 7'h01, 4'h0, 7'h00, 1'b0},
    '{7'h00, 7'h7f, 4'h0, 7'h7f, 1'b0},
    '{7'h00, 7'h00, 4'h1, 7'h00, 1'b0},
    '{7'h01, 7'h00, 4'h1, 7'h00, 1'b1},
    '{7'h01, 7'h00, 4'h2, 7'h01, 1'b0},
    '{7'h01, 7'h00, 4'h2, 7'h00, 1'b1}
  };
  logic                  clk, srst, ce, wr, rd, key, grp, scada, boot, fault, sok, led;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdat, rdat;
  logic [NCH*TRIG_N-1:0] trig;
  logic [NCH-1:0]        ack, relay, closed;
  int                    errors, n_checks;

  lrol_top #(.NUM_CH(NCH), .TICK_CYC(4)) lrol_top_i (
    .ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr), .rd_i(rd), .trig_i(trig), .ack_sig_i(ack), .clear_key_i(key),
    .group_output_ack_signal_i(grp), .scada_ack_i(scada), .boot_done_i(boot),
    .fault_i(fault), .rd_data_o(rdat), .relay_o(relay), .system_ok_contact_o(sok),
    .system_ok_led_o(led));
  lrol_load_model #(.N(NCH)) lrol_load_model_i (.coil_i(relay), .closed_o(closed));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic fail(string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic wait_n(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_rel(logic [NCH-1:0] e);
    n_checks++;
    if (relay !== e || closed !== e) fail("relay drive");
  endtask
  task automatic chk_sys(logic c, logic l);
    n_checks++;
    if (sok !== c || led !== l) fail("system ok outputs");
  endtask
  task automatic chk_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    n_checks++;
    if (rdat !== e) fail("read data");
  endtask
  task automatic wreg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic trg(logic [NCH*TRIG_N-1:0] t);
    @(posedge clk);
    trig <= t;
    wait_n(4);
  endtask
  // Bits of s are {scada, group, clear key}; all acknowledges are one cycle long.
  task automatic pulse(logic [2:0] s, logic [NCH-1:0] a);
    @(posedge clk);
    {scada, grp, key} <= s;
    ack <= a;
    @(posedge clk);
    {scada, grp, key} <= 3'h0;
    ack <= 2'h0;
    wait_n(4);
  endtask
  function automatic logic [31:0] cfg(logic [6:0] asg, logic [6:0] inv, logic [3:0] f);
    return {12'h000, f, 1'b0, inv, 1'b0, asg};
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    {srst, wr, rd, key, grp, scada, boot, fault} = 8'h80;
    ce = 1'b1;
    addr = 8'h00;
    wdat = 32'h0000_0000;
    trig = 14'h0000;
    ack = 2'h0;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wait_n(100);
    chk_sys(1'b0, 1'b0);
    wait_n(1000);
    chk_sys(1'b0, 1'b1);
    @(posedge clk);
    boot <= 1'b1;
    wait_n(3);
    chk_sys(1'b1, 1'b1);
    @(posedge clk);
    fault <= 1'b1;
    wait_n(3);
    chk_sys(1'b0, 1'b1);
    @(posedge clk);
    fault <= 1'b0;
    foreach (ROWS[i]) begin
      wreg(OFS_CH_CFG, cfg(ROWS[i].asg, ROWS[i].inv, ROWS[i].f));
      trg({7'h00, ROWS[i].t});
      chk_rel({1'b0, ROWS[i].e});
    end
    // A low clock enable must freeze the closed-circuit channel as it stands.
    @(posedge clk);
    ce <= 1'b0;
    trg(14'h0001);
    chk_rel(2'h1);
    @(posedge clk);
    ce <= 1'b1;
    wait_n(4);
    chk_rel(2'h0);
    wreg(8'h80, 32'hffff_ffff);
    chk_reg(8'h80, 32'h0000_0000);
    wreg(OFS_CH_CFG + 8'h08, 32'hffff_ffff);
    chk_reg(OFS_CH_CFG + 8'h08, 32'h0000_0000);
    wreg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'hc));
    chk_reg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'hc));
    trg(14'h0001);
    pulse(3'h0, 2'h1);
    chk_rel(2'h1);
    trg(14'h0000);
    chk_rel(2'h1);
    chk_reg(OFS_STATUS, 32'h0001_0001);
    pulse(3'h0, 2'h1);
    chk_rel(2'h0);
    wreg(OFS_TIMING, 32'h0005_0000);
    trg(14'h0001);
    trg(14'h0000);
    pulse(3'h1, 2'h0);
    chk_rel(2'h1);
    wait_n(30);
    pulse(3'h1, 2'h0);
    chk_rel(2'h0);
    wreg(OFS_TIMING, 32'h0000_0000);
    trg(14'h0001);
    trg(14'h0000);
    wreg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'h0));
    wait_n(4);
    chk_rel(2'h0);
    wreg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'h4));
    trg(14'h0001);
    trg(14'h0000);
    wreg(OFS_CH_CFG, cfg(7'h00, 7'h00, 4'h4));
    wait_n(4);
    chk_rel(2'h0);
    wreg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'h0));
    wreg(OFS_TIMING, 32'h0000_0005);
    trg(14'h0001);
    trg(14'h0000);
    wait_n(4);
    chk_rel(2'h1);
    wait_n(40);
    chk_rel(2'h0);
    wreg(OFS_TIMING, 32'h0000_0000);
    wreg(OFS_CH_CFG, cfg(7'h01, 7'h00, 4'hc));
    wreg(OFS_CH_CFG + 8'h04, cfg(7'h01, 7'h00, 4'h4));
    trg(14'h0081);
    trg(14'h0000);
    pulse(3'h6, 2'h3);
    chk_rel(2'h2);
    wreg(OFS_GLOBAL, 32'h0000_0001);
    chk_reg(OFS_GLOBAL, 32'h0000_0001);
    pulse(3'h2, 2'h0);
    chk_rel(2'h0);
    trg(14'h0081);
    trg(14'h0000);
    pulse(3'h4, 2'h0);
    chk_rel(2'h0);
    trg(14'h0001);
    trg(14'h0000);
    @(posedge clk);
    srst <= 1'b1;
    wait_n(2);
    @(posedge clk);
    srst <= 1'b0;
    wait_n(8);
    chk_rel(2'h1);
    chk_reg(OFS_TIMING, 32'h0000_0000);
    chk_reg(OFS_GLOBAL, 32'h0000_0000);
    pulse(3'h1, 2'h0);
    chk_rel(2'h0);
    conclude();
  end
endmodule // tb_lrol_top
`default_nettype wire
